//--- include/vcsd_pkg.sv
// Purpose: shared constants and types of the vector compare/search/dot unit
// Assumes: 64-bit words, length in bits 63:48, address or count in bits 47:0
// Notes: exponent 16 bits signed over coefficient 48 bits signed (32-bit: 8 over 24)
package vcsd_pkg;
  // descriptor register fields
  localparam int LEN_HI = 63;
  localparam int LEN_LO = 48;
  // data flag bit positions
  localparam int FLG_OVFL = 42;
  localparam int FLG_MZERO = 43;
  localparam int FLG_INDEF = 46;
  // option (G) bits
  localparam int G_HALF = 0;
  localparam int G_CTLV = 1;
  localparam int G_FROM_HIT = 2;
  localparam int G_BCAST_A = 3;
  localparam int G_BCAST_B = 4;
  // operation codes
  localparam logic [7:0] OP_DOT = 8'hdd;
  localparam logic [5:0] OP_CMP_GRP = 6'h31;
  localparam logic [5:0] OP_SRCH_GRP = 6'h32;
  localparam logic [1:0] CND_EQ = 2'h0;
  localparam logic [1:0] CND_NE = 2'h1;
  localparam logic [1:0] CND_GE = 2'h2;
  localparam logic [1:0] CND_LT = 2'h3;
  // floating point encodings
  localparam logic [3:0] EXP_INDEF = 4'h7;
  localparam logic [3:0] EXP_MZERO = 4'h8;
  localparam logic [15:0] INDEF_EXP = 16'h7000;
  localparam logic [15:0] MZERO_EXP = 16'h8000;
  localparam logic signed [17:0] EXP_MAX = 18'sh06fff;
  localparam logic signed [17:0] EXP_MIN = -18'sh07000;
  localparam logic signed [17:0] UPPER_SHIFT = 18'sh00030;
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_DOT = 7'h02,
    ST_DSUM = 7'h04,
    ST_DHI = 7'h08,
    ST_DLO = 7'h10,
    ST_CMP = 7'h20,
    ST_SRCH = 7'h40
  } vcsd_state_e;
endpackage : vcsd_pkg

//--- rtl/vcsd_unit.sv
// Purpose: sparse dot product, compare to order vector, search to index list
// Assumes: issue logic and storage stream operands on the same clock
// Notes: results leave through a two-entry buffer; RES_TO_REG marks register writes
// Summary of operation
// (RULE1) dot: multiply pairs, accumulate, double unnormalized
// (RULE2) product added only when both order bits set
// (RULE3) upper to register C, lower to C+1
// (RULE4) option bit 0 picks 64 or 32-bit elements
// (RULE5) issuer zeroes Z and option bits 1-7
// (RULE6) order descriptors: address low 48, length high 16
// (RULE7) dot ends after shorter order vector examined
// (RULE8) issuer gives even nonzero result register
// (RULE9) no enabled products gives machine zero
// (RULE10) overflow from multiplies; zero/indefinite from final result
// (RULE11) indefinite upper: lower below 9000, upper kept
// (RULE12) two partial sums, then added together
// (RULE13) compare A minus B, four conditions set bit
// (RULE14) compare ends when order vector field filled
// (RULE15) issuer zeroes compare option bits and designator
// (RULE16) offsets from two registers; broadcast needs none
// (RULE17) source lengths in elements, order vector bits
// (RULE18) compare reports only indefinite flag
// (RULE19) search each A over B until hit or end
// (RULE20) store cleared word with miss count low 48
// (RULE21) option bit 1: control vector gates stores
// (RULE22) issuer zeroes search designators and bits 11-15
// (RULE23) option bit 2: restart at B start or hit
`timescale 1ns/1ps
module vcsd_unit
  import vcsd_pkg::*;
#(
  parameter int LEN_W = 16,
  parameter int BUF_DEPTH = 2
) (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic ARST_N,
  input wire logic CE,
  // instruction issue
  input wire logic START,
  input wire logic [7:0] OPCODE,
  input wire logic [15:0] OPT_G,
  input wire logic [7:0] RES_DESIG,
  input wire logic [63:0] REG_A,
  input wire logic [63:0] REG_B,
  input wire logic [63:0] REG_X,
  input wire logic [63:0] REG_Y,
  input wire logic [63:0] REG_Z,
  output logic BUSY,
  output logic DONE,
  output logic [63:0] DATA_FLAGS,
  // order vector bits
  input wire logic OV_VALID,
  input wire logic OV_X,
  input wire logic OV_Y,
  output logic OV_READY,
  // vector A stream with control vector bit
  input wire logic A_VALID,
  input wire logic [63:0] A_DATA,
  input wire logic A_CV,
  output logic A_READY,
  // vector B stream
  input wire logic B_VALID,
  input wire logic [63:0] B_DATA,
  output logic B_READY,
  output logic [LEN_W-1:0] B_IDX,
  // results
  output logic RES_VALID,
  input wire logic RES_READY,
  output logic [63:0] RES_DATA,
  output logic RES_TO_REG,
  output logic [7:0] RES_REG,
  output logic [LEN_W-1:0] RES_IDX
);
  localparam int EW = 1 + 8 + LEN_W + 64;
  localparam int PW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
  localparam int CW = $clog2(BUF_DEPTH + 1);

  function automatic logic [LEN_W-1:0] f_len(input logic [63:0] r);
    f_len = LEN_W'(r[LEN_HI:LEN_LO]);
  endfunction : f_len

  function automatic logic f_ind(input logic [63:0] d, input logic h);
    f_ind = h ? (d[31:28] == EXP_INDEF) : (d[63:60] == EXP_INDEF);
  endfunction : f_ind

  function automatic logic f_mz(input logic [63:0] d, input logic h);
    f_mz = h ? (d[31:28] == EXP_MZERO) : (d[63:60] == EXP_MZERO);
  endfunction : f_mz

  function automatic logic signed [17:0] f_exp(input logic [63:0] d, input logic h);
    f_exp = h ? {{10{d[31]}}, d[31:24]} : {{2{d[63]}}, d[63:48]};
  endfunction : f_exp

  function automatic logic signed [47:0] f_coef(input logic [63:0] d, input logic h);
    if (f_mz(d, h)) begin
      f_coef = '0;
    end else begin
      f_coef = h ? {{24{d[23]}}, d[23:0]} : d[47:0];
    end
  endfunction : f_coef

  // returns {a less than b, a equal to b} after exponent alignment
  function automatic logic [1:0] f_cmp(input logic [63:0] a, b, input logic h);
    logic signed [17:0] df;
    logic [17:0] sh;
    logic [5:0] sa;
    logic signed [63:0] ca, cb;
    begin
      df = f_exp(a, h) - f_exp(b, h);
      sh = df[17] ? 18'(-df) : 18'(df);
      sa = (sh > 18'd63) ? 6'd63 : sh[5:0];
      ca = 64'(f_coef(a, h));
      cb = 64'(f_coef(b, h));
      if (df[17]) begin
        ca = ca >>> sa;
      end else begin
        cb = cb >>> sa;
      end
      f_cmp = {ca < cb, ca == cb};
    end
  endfunction : f_cmp

  function automatic logic f_hit(input logic [1:0] c, input logic [1:0] le);
    case (c)
      CND_EQ: f_hit = le[0];
      CND_NE: f_hit = !le[0];
      CND_GE: f_hit = !le[1];
      default: f_hit = le[1];
    endcase
  endfunction : f_hit

  // unnormalized add: smaller exponent shifted right, no renormalization
  function automatic logic [115:0] f_add(input logic signed [17:0] e1, e2,
      input logic signed [97:0] c1, c2);
    logic signed [17:0] df;
    logic [17:0] sh;
    logic [6:0] sa;
    logic signed [97:0] a1, a2;
    begin
      df = e1 - e2;
      sh = df[17] ? 18'(-df) : 18'(df);
      sa = (sh > 18'd97) ? 7'd97 : sh[6:0];
      a1 = df[17] ? (c1 >>> sa) : c1;
      a2 = df[17] ? c2 : (c2 >>> sa);
      if (c1 == '0) begin
        f_add = {e2, c2};
      end else if (c2 == '0) begin
        f_add = {e1, c1};
      end else begin
        f_add = {(df[17] ? e2 : e1), 98'(a1 + a2)};
      end
    end
  endfunction : f_add

  vcsd_state_e st_q;
  logic [7:0] op_q, desig_q;
  logic [15:0] g_q;
  logic [LEN_W-1:0] lena_q, lenb_q, lim_q, pos_q, ai_q, bj_q, bst_q;
  logic [63:0] cona_q, conb_q, a_q, hi_q, lo_q;
  logic ahave_q, cv_q, ovf_q, mz_q, ind_q, done_q, acc_ind_q;
  logic signed [17:0] xe_q, ye_q;
  logic signed [97:0] xc_q, yc_q;
  logic [EW-1:0] mem_q [BUF_DEPTH];
  logic [PW-1:0] wp_q, rp_q;
  logic [CW-1:0] cnt_q;

  logic half, bca, bcb, room, hit, op_ind, store_en;
  logic dot_go, cmp_go, s_act, s_load, s_end, s_cmp, s_done, push, pop;
  logic pr_ind, pr_mz;
  logic [1:0] cmpr;
  logic [63:0] opa, opb, hi_d, lo_d;
  logic signed [17:0] pr_e, se, ue;
  logic signed [97:0] pr_c, sc;
  logic [115:0] acc_sum, fin_sum;
  logic [EW-1:0] push_w, rd_w;

  always_comb begin
    half = g_q[G_HALF]; // RULE4
    bca = (st_q == ST_CMP) && g_q[G_BCAST_A]; // RULE16
    bcb = (st_q == ST_CMP) && g_q[G_BCAST_B]; // RULE16
    room = (cnt_q != CW'(BUF_DEPTH));
    opa = (st_q == ST_SRCH) ? a_q : (bca ? cona_q : A_DATA);
    opb = bcb ? conb_q : B_DATA;
    cmpr = f_cmp(opa, opb, half); // RULE13
    hit = f_hit(op_q[1:0], cmpr); // RULE13
    op_ind = f_ind(opa, half) || f_ind(opb, half);
    pr_e = f_exp(opa, half) + f_exp(opb, half); // RULE1
    pr_c = 98'(f_coef(opa, half) * f_coef(opb, half)); // RULE1
    pr_ind = op_ind || (pr_e > EXP_MAX);
    pr_mz = f_mz(opa, half) || f_mz(opb, half) || (pr_e < EXP_MIN);
    acc_sum = pos_q[0] ? f_add(ye_q, pr_e, yc_q, pr_c) : f_add(xe_q, pr_e, xc_q, pr_c);
    // dot consumes an element only where its own order bit is set
    dot_go = CE && (st_q == ST_DOT) && (pos_q != lim_q) && OV_VALID
      && (!OV_X || A_VALID) && (!OV_Y || B_VALID);
    cmp_go = CE && (st_q == ST_CMP) && (pos_q != lim_q)
      && (bca || A_VALID) && (bcb || B_VALID) && room;
    s_act = CE && (st_q == ST_SRCH) && ahave_q && room;
    s_load = CE && (st_q == ST_SRCH) && !ahave_q && (ai_q != lena_q) && A_VALID;
    s_end = s_act && (bj_q == lenb_q); // RULE19
    s_cmp = s_act && (bj_q != lenb_q) && B_VALID;
    s_done = s_end || (s_cmp && hit); // RULE19
    store_en = !g_q[G_CTLV] || cv_q; // RULE21
  end

  // final sum and result formatting
  always_comb begin
    fin_sum = f_add(xe_q, ye_q, xc_q, yc_q); // RULE12
    se = fin_sum[115:98];
    sc = fin_sum[97:0];
    ue = se + UPPER_SHIFT;
    if (acc_ind_q) begin
      hi_d = {INDEF_EXP, sc[95:48]}; // RULE11
      lo_d = {MZERO_EXP, sc[47:0]}; // RULE11
    end else begin
      hi_d = (sc == '0 || ue < EXP_MIN) ? {MZERO_EXP, 48'h0} : {ue[15:0], sc[95:48]}; // RULE9
      lo_d = (sc == '0 || se < EXP_MIN) ? {MZERO_EXP, 48'h0} : {se[15:0], sc[47:0]}; // RULE9
    end
  end

  always_comb begin
    push = 1'b0;
    push_w = '0;
    if (cmp_go) begin
      push = 1'b1;
      push_w = {1'b0, 8'h00, pos_q, 63'h0, hit}; // RULE13
    end else if (s_done) begin
      push = store_en; // RULE21
      push_w = {1'b0, 8'h00, ai_q, 64'(LEN_W'(bj_q - bst_q))}; // RULE20
    end else if (CE && room && st_q == ST_DHI) begin
      push = 1'b1;
      push_w = {1'b1, desig_q, LEN_W'(0), hi_q}; // RULE3
    end else if (CE && room && st_q == ST_DLO) begin
      push = 1'b1;
      push_w = {1'b1, 8'(desig_q + 8'h01), LEN_W'(1), lo_q}; // RULE3 RULE8
    end
  end

  assign OV_READY = dot_go;
  assign A_READY = (dot_go && OV_X) || (cmp_go && !bca) || s_load;
  assign B_READY = (dot_go && OV_Y) || (cmp_go && !bcb) || s_cmp;
  assign B_IDX = bj_q;
  assign BUSY = (st_q != ST_IDLE);
  assign DONE = done_q;

  always_comb begin
    DATA_FLAGS = '0;
    DATA_FLAGS[FLG_OVFL] = ovf_q;
    DATA_FLAGS[FLG_MZERO] = mz_q;
    DATA_FLAGS[FLG_INDEF] = ind_q;
  end

  // sequencing
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      st_q <= ST_IDLE;
      op_q <= '0;
      g_q <= '0;
      desig_q <= '0;
      lena_q <= '0;
      lenb_q <= '0;
      lim_q <= '0;
      pos_q <= '0;
      ai_q <= '0;
      bj_q <= '0;
      bst_q <= '0;
      cona_q <= '0;
      conb_q <= '0;
      a_q <= '0;
      cv_q <= 1'b0;
      ahave_q <= 1'b0;
      hi_q <= '0;
      lo_q <= '0;
      done_q <= 1'b0;
    end else if (CE) begin
      done_q <= 1'b0;
      case (st_q)
        ST_IDLE: begin
          if (START) begin
            op_q <= OPCODE;
            g_q <= OPT_G; // RULE5 RULE15 RULE22
            desig_q <= RES_DESIG;
            cona_q <= REG_A;
            conb_q <= REG_B;
            lena_q <= f_len(REG_A); // RULE17
            lenb_q <= f_len(REG_B); // RULE17
            pos_q <= '0;
            ai_q <= '0;
            bj_q <= '0;
            bst_q <= '0;
            ahave_q <= 1'b0;
            if (OPCODE == OP_DOT) begin
              st_q <= ST_DOT;
              // shorter of the two order vectors bounds the scan
              lim_q <= (f_len(REG_X) < f_len(REG_Y)) ? f_len(REG_X) : f_len(REG_Y); // RULE6 RULE7
            end else if (OPCODE[7:2] == OP_CMP_GRP) begin
              st_q <= ST_CMP;
              lim_q <= f_len(REG_Z); // RULE14 RULE17
            end else if (OPCODE[7:2] == OP_SRCH_GRP) begin
              st_q <= ST_SRCH;
            end else begin
              done_q <= 1'b1;
            end
          end
        end
        ST_DOT: begin
          if (dot_go) begin
            pos_q <= LEN_W'(pos_q + 1'b1);
            bj_q <= OV_Y ? LEN_W'(bj_q + 1'b1) : bj_q;
          end else if (pos_q == lim_q) begin
            st_q <= ST_DSUM; // RULE7
          end
        end
        ST_DSUM: begin
          hi_q <= hi_d;
          lo_q <= lo_d;
          st_q <= ST_DHI;
        end
        ST_DHI: begin
          if (room) begin
            st_q <= ST_DLO;
          end
        end
        ST_DLO: begin
          if (room) begin
            st_q <= ST_IDLE;
            done_q <= 1'b1;
          end
        end
        ST_CMP: begin
          if (cmp_go) begin
            pos_q <= LEN_W'(pos_q + 1'b1);
            bj_q <= LEN_W'(bj_q + 1'b1);
          end else if (pos_q == lim_q) begin
            st_q <= ST_IDLE; // RULE14
            done_q <= 1'b1;
          end
        end
        ST_SRCH: begin
          if (s_load) begin
            a_q <= A_DATA;
            cv_q <= A_CV;
            ahave_q <= 1'b1;
            bj_q <= bst_q; // RULE23
          end else if (s_done) begin
            ahave_q <= 1'b0;
            ai_q <= LEN_W'(ai_q + 1'b1);
            bst_q <= g_q[G_FROM_HIT] ? bj_q : '0; // RULE23
          end else if (s_cmp) begin
            bj_q <= LEN_W'(bj_q + 1'b1); // RULE19
          end else if (!ahave_q && ai_q == lena_q) begin
            st_q <= ST_IDLE;
            done_q <= 1'b1;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // partial sums: even positions into one, odd positions into the other
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      xe_q <= '0;
      ye_q <= '0;
      xc_q <= '0;
      yc_q <= '0;
      acc_ind_q <= 1'b0;
    end else if (CE) begin
      if (st_q == ST_IDLE && START) begin
        xc_q <= '0;
        yc_q <= '0;
        xe_q <= '0;
        ye_q <= '0;
        acc_ind_q <= 1'b0;
      end else if (dot_go && OV_X && OV_Y) begin // RULE2
        if (pr_ind) begin
          acc_ind_q <= 1'b1;
        end else if (!pr_mz && pos_q[0]) begin
          ye_q <= acc_sum[115:98]; // RULE12
          yc_q <= acc_sum[97:0];
        end else if (!pr_mz) begin
          xe_q <= acc_sum[115:98]; // RULE12
          xc_q <= acc_sum[97:0];
        end
      end
    end
  end

  // data flags
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      ovf_q <= 1'b0;
      mz_q <= 1'b0;
      ind_q <= 1'b0;
    end else if (CE) begin
      if (st_q == ST_IDLE && START) begin
        ovf_q <= 1'b0;
        mz_q <= 1'b0;
        ind_q <= 1'b0;
      end else if (dot_go && OV_X && OV_Y && pr_e > EXP_MAX) begin
        ovf_q <= 1'b1; // RULE10
      end else if ((cmp_go || s_cmp) && op_ind) begin
        ind_q <= 1'b1; // RULE18
      end else if (st_q == ST_DSUM) begin
        mz_q <= (hi_d[63:60] == EXP_MZERO) || (lo_d[63:60] == EXP_MZERO); // RULE10
        ind_q <= (hi_d[63:60] == EXP_INDEF); // RULE10
      end
    end
  end

  // result buffer
  assign pop = CE && (cnt_q != '0) && RES_READY;
  assign rd_w = mem_q[rp_q];
  assign RES_VALID = CE && (cnt_q != '0);
  assign RES_TO_REG = rd_w[EW-1];
  assign RES_REG = rd_w[EW-2:EW-9];
  assign RES_IDX = rd_w[64+LEN_W-1:64];
  assign RES_DATA = rd_w[63:0];

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      for (int i = 0; i < BUF_DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else if (CE) begin
      if (push) begin
        mem_q[wp_q] <= push_w;
        wp_q <= (wp_q == PW'(BUF_DEPTH - 1)) ? '0 : PW'(wp_q + 1'b1);
      end
      if (pop) begin
        rp_q <= (rp_q == PW'(BUF_DEPTH - 1)) ? '0 : PW'(rp_q + 1'b1);
      end
      if (push && !pop) begin
        cnt_q <= CW'(cnt_q + 1'b1);
      end else if (pop && !push) begin
        cnt_q <= CW'(cnt_q - 1'b1);
      end
    end
  end
endmodule : vcsd_unit

//--- test/vcsd_unit_asserts.sv
// Purpose: port checks of the vector compare/search/dot unit
// Assumes: one clock, async active-low reset
// Notes: helper flops keep the operation taken at start
`timescale 1ns/1ps
module vcsd_unit_asserts
  import vcsd_pkg::*;
#(
  parameter int LEN_W = 16
) (
  // clock, reset, issue
  input wire logic CLK_SYS,
  input wire logic ARST_N,
  input wire logic CE,
  input wire logic START,
  input wire logic BUSY,
  input wire logic DONE,
  input wire logic [7:0] OPCODE,
  input wire logic [7:0] RES_DESIG,
  input wire logic [63:0] REG_X,
  input wire logic [63:0] REG_Y,
  input wire logic [63:0] REG_Z,
  input wire logic [63:0] DATA_FLAGS,
  // streams
  input wire logic OV_VALID,
  input wire logic OV_X,
  input wire logic OV_Y,
  input wire logic OV_READY,
  input wire logic A_READY,
  // results
  input wire logic RES_VALID,
  input wire logic RES_READY,
  input wire logic [63:0] RES_DATA,
  input wire logic RES_TO_REG,
  input wire logic [7:0] RES_REG,
  input wire logic [LEN_W-1:0] RES_IDX
);
  logic [7:0] op_q;
  logic [7:0] desig_q;
  logic [LEN_W-1:0] zlen_q;
  logic [15:0] lim_q;
  logic [15:0] pos_q;
  logic en_q;
  logic take;
  logic cmp;
  logic srch;
  assign take = CE && START && !BUSY;
  assign cmp = op_q[7:2] == OP_CMP_GRP;
  assign srch = op_q[7:2] == OP_SRCH_GRP;
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      op_q <= 8'h00;
      desig_q <= 8'h00;
      zlen_q <= '0;
      lim_q <= 16'h0;
    end else if (take) begin
      op_q <= OPCODE;
      desig_q <= RES_DESIG;
      zlen_q <= LEN_W'(REG_Z[LEN_HI:LEN_LO]);
      lim_q <= (REG_X[63:48] < REG_Y[63:48]) ? REG_X[63:48] : REG_Y[63:48];
    end
  end
  // order positions examined and whether any product was enabled
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      pos_q <= 16'h0;
      en_q <= 1'b0;
    end else if (take) begin
      pos_q <= 16'h0;
      en_q <= 1'b0;
    end else if (OV_VALID && OV_READY) begin
      pos_q <= pos_q + 16'h1;
      en_q <= en_q || (OV_X && OV_Y);
    end
  end
  default clocking dc @(posedge CLK_SYS); endclocking
  default disable iff (!ARST_N);
  chk_dot_dest_reg: assert property (
    RES_VALID && RES_TO_REG |-> RES_REG == desig_q + 8'(RES_IDX))
    else $error("dot result register wrong");
  chk_dot_hi_lo: assert property (
    RES_VALID && RES_READY && RES_TO_REG && RES_IDX == '0
    |=> ##[0:8] (RES_VALID && RES_TO_REG && RES_IDX == LEN_W'(1)))
    else $error("lower dot word missing");
  chk_no_prod_zero: assert property (
    RES_VALID && RES_TO_REG && op_q == OP_DOT && !en_q |-> RES_DATA[63:60] == EXP_MZERO)
    else $error("empty dot not machine zero");
  chk_mzero_flag: assert property (
    DONE && !START && op_q == OP_DOT && !en_q |=> DATA_FLAGS[FLG_MZERO])
    else $error("machine zero flag missing");
  chk_cmp_flags: assert property (
    BUSY && cmp |-> (DATA_FLAGS & ~(64'h1 << FLG_INDEF)) == 64'h0)
    else $error("compare raised other flag");
  chk_cmp_bit_only: assert property (
    RES_VALID && cmp |-> RES_DATA[63:1] == 63'h0 && !RES_TO_REG)
    else $error("compare beat not one bit");
  chk_cmp_fill: assert property (
    RES_VALID && cmp |-> RES_IDX < zlen_q)
    else $error("compare wrote past field");
  chk_srch_count_hi: assert property (
    RES_VALID && srch |-> RES_DATA[63:48] == 16'h0)
    else $error("search count upper bits set");
  chk_ov_limit: assert property (
    OV_READY |-> pos_q < lim_q)
    else $error("order bit taken past shorter vector");
  chk_a_with_x: assert property (
    OV_VALID && OV_READY && OV_X |-> A_READY)
    else $error("A element not paired with order bit");
endmodule : vcsd_unit_asserts

//--- test/vcsd_store_model.sv
// Purpose: storage side: order bits, A and B element streams
// Assumes: bench loads the arrays once before the table rows and again before each dot
// Notes: slow mode drops valid on even cycles; idle data is inverted
`timescale 1ns/1ps
module vcsd_store_model (
  // clock, reset, control
  input wire logic clk,
  input wire logic arst_n,
  input wire logic restart,
  input wire logic slow,
  // handshakes from the unit
  input wire logic ov_ready,
  input wire logic a_ready,
  input wire logic [15:0] b_idx,
  // streams
  output logic ov_valid,
  output logic ov_x,
  output logic ov_y,
  output logic a_valid,
  output logic [63:0] a_data,
  output logic a_cv,
  output logic b_valid,
  output logic [63:0] b_data
);
  logic [63:0] a_mem [4];
  logic [63:0] b_mem [4];
  logic [3:0] ovx_mem;
  logic [3:0] ovy_mem;
  logic [3:0] cv_mem;
  logic [2:0] a_ptr;
  logic [2:0] ov_ptr;
  logic ph;
  logic go;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ph <= 1'b0;
      a_ptr <= 3'h0;
      ov_ptr <= 3'h0;
    end else begin
      ph <= ~ph;
      if (restart) begin
        a_ptr <= 3'h0;
        ov_ptr <= 3'h0;
      end else begin
        if (a_valid && a_ready) a_ptr <= a_ptr + 3'h1;
        if (ov_valid && ov_ready) ov_ptr <= ov_ptr + 3'h1;
      end
    end
  end
  assign go = !slow || ph;
  assign ov_valid = go && !ov_ptr[2];
  assign ov_x = ov_valid ? ovx_mem[ov_ptr[1:0]] : ~ovx_mem[ov_ptr[1:0]];
  assign ov_y = ov_valid ? ovy_mem[ov_ptr[1:0]] : ~ovy_mem[ov_ptr[1:0]];
  assign a_valid = go && !a_ptr[2];
  assign a_data = a_valid ? a_mem[a_ptr[1:0]] : ~a_mem[a_ptr[1:0]];
  assign a_cv = a_valid ? cv_mem[a_ptr[1:0]] : ~cv_mem[a_ptr[1:0]];
  assign b_valid = go && b_idx < 16'h4;
  assign b_data = b_valid ? b_mem[b_idx[1:0]] : ~b_mem[b_idx[1:0]];
endmodule : vcsd_store_model

//--- test/vcsd_unit_bench.sv
// Purpose: self-checking bench of the compare/search/dot unit
// Assumes: storage model answers on the unit's clock
// Notes: table covers compare and search codes; dot and stalls follow
`timescale 1ns/1ps
module vcsd_unit_bench;
  import vcsd_pkg::*;
  typedef struct packed {
    logic [7:0] op;
    logic [15:0] g;
    logic [15:0] la;
    logic [15:0] lz;
    logic [7:0] n;
    logic [31:0] e;
  } vcsd_row_s;
  logic CLK_SYS = 1'b0, ARST_N = 1'b0, CE = 1'b1, START = 1'b0, RES_READY = 1'b1;
  logic [7:0] OPCODE = 8'h00, RES_DESIG = 8'h00;
  logic [15:0] OPT_G = 16'h0;
  logic [63:0] REG_A = 64'h0, REG_B = 64'h0, REG_X = 64'h0, REG_Y = 64'h0, REG_Z = 64'h0;
  logic BUSY, DONE, OV_VALID, OV_X, OV_Y, OV_READY, A_VALID, A_CV, A_READY, B_VALID, B_READY;
  logic RES_VALID, RES_TO_REG;
  logic [63:0] DATA_FLAGS, A_DATA, B_DATA, RES_DATA;
  logic [7:0] RES_REG;
  logic [15:0] B_IDX, RES_IDX;
  logic slow = 1'b0, hold = 1'b0;
  int error_cnt = 0, samples_checked = 0, cyc = 0;
  logic [63:0] got_q [$];
  logic [7:0] reg_q [$];
  vcsd_row_s rows [10] = '{
    '{8'hc4, 16'h10, 16'h4, 16'h4, 8'h4, 32'h01000100},
    '{8'hc5, 16'h10, 16'h4, 16'h4, 8'h4, 32'h00010001},
    '{8'hc6, 16'h10, 16'h4, 16'h4, 8'h4, 32'h01010100},
    '{8'hc7, 16'h10, 16'h4, 16'h4, 8'h4, 32'h00000001},
    '{8'hc8, 16'h0, 16'h2, 16'h0, 8'h2, 32'h00000002},
    '{8'hc9, 16'h0, 16'h2, 16'h0, 8'h2, 32'h00000100},
    '{8'hca, 16'h0, 16'h2, 16'h0, 8'h2, 32'h00000002},
    '{8'hcb, 16'h0, 16'h2, 16'h0, 8'h2, 32'h00000100},
    '{8'hc8, 16'h4, 16'h2, 16'h0, 8'h2, 32'h00000202},
    '{8'hc8, 16'h2, 16'h2, 16'h0, 8'h1, 32'h00000002}
  };
  vcsd_unit dut_u (.CLK_SYS, .ARST_N, .CE, .START, .OPCODE, .OPT_G, .RES_DESIG, .REG_A,
    .REG_B, .REG_X, .REG_Y, .REG_Z, .BUSY, .DONE, .DATA_FLAGS, .OV_VALID, .OV_X, .OV_Y,
    .OV_READY, .A_VALID, .A_DATA, .A_CV, .A_READY, .B_VALID, .B_DATA, .B_READY, .B_IDX,
    .RES_VALID, .RES_READY, .RES_DATA, .RES_TO_REG, .RES_REG, .RES_IDX);
  vcsd_store_model part_u (.clk(CLK_SYS), .arst_n(ARST_N), .restart(START && !BUSY),
    .slow(slow), .ov_ready(OV_READY), .a_ready(A_READY), .b_idx(B_IDX), .ov_valid(OV_VALID),
    .ov_x(OV_X), .ov_y(OV_Y), .a_valid(A_VALID), .a_data(A_DATA), .a_cv(A_CV),
    .b_valid(B_VALID), .b_data(B_DATA));
  always #2.5 CLK_SYS = ~CLK_SYS;
  always @(posedge CLK_SYS) begin
    RES_READY <= #1 !hold && (!slow || cyc[0]);
    cyc <= cyc + 1;
    if (ARST_N && RES_VALID && RES_READY) begin
      got_q.push_back(RES_DATA);
      reg_q.push_back(RES_REG);
    end
    if (cyc == 5000) begin
      error_cnt++;
      stop_test();
    end
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic run(input logic [7:0] op, input logic [15:0] g, input logic [15:0] la,
    input logic [15:0] lz, input logic [63:0] rb);
    int n;
    got_q.delete();
    reg_q.delete();
    @(posedge CLK_SYS);
    #1;
    OPCODE = op;
    OPT_G = g;
    REG_A = {la, 48'h0};
    REG_B = rb;
    REG_Z = {lz, 48'h0};
    START = 1'b1;
    @(posedge CLK_SYS);
    #1;
    START = 1'b0;
    n = 0;
    while (DONE !== 1'b1 && n < 400) begin
      @(posedge CLK_SYS);
      #1;
      n++;
    end
    if (n == 400) error_cnt++;
    repeat (8) @(posedge CLK_SYS);
    #1;
  endtask : run
  task automatic dot(input logic [3:0] ox, input logic [3:0] oy, input logic [15:0] lx,
    input logic [15:0] ly, input logic [63:0] av, input logic [63:0] bv);
    part_u.ovx_mem = ox;
    part_u.ovy_mem = oy;
    part_u.a_mem = '{av, av, av, av};
    part_u.b_mem = '{bv, bv, bv, bv};
    REG_X = {lx, 48'h0};
    REG_Y = {ly, 48'h0};
    RES_DESIG = 8'h0a;
    run(OP_DOT, 16'h0, 16'h0, 16'h0, 64'h0);
    chk(64'(reg_q[0]), 64'h0a);
    chk(64'(reg_q[1]), 64'h0b);
  endtask : dot
  task automatic stop_test;
    $display("checked %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test
  initial begin
    part_u.cv_mem = 4'b0001;
    repeat (12) @(posedge CLK_SYS);
    chk(64'({BUSY, DONE, RES_VALID, A_READY, B_READY, OV_READY}), 64'h0);
    chk(DATA_FLAGS, 64'h0);
    #1;
    ARST_N = 1'b1;
    part_u.a_mem = '{64'h1, 64'h2, 64'h3, 64'h2};
    part_u.b_mem = '{64'h2, 64'h3, 64'h1, 64'h4};
    foreach (rows[i]) begin
      run(rows[i].op, rows[i].g, rows[i].la, rows[i].lz,
        rows[i].op[3] ? 64'h0004_0000_0000_0000 : 64'h2);
      chk(64'(got_q.size()), 64'(rows[i].n));
      for (int j = 0; j < rows[i].n; j++) begin
        chk(got_q[j], 64'(rows[i].e[j*8 +: 8]));
      end
      chk(DATA_FLAGS, 64'h0);
    end
    run(8'hc8, 16'h4, 16'h2, 16'h0, 64'h0);
    chk(got_q[0], 64'h0);
    chk(got_q[1], 64'h0);
    run(8'hc4, 16'h11, 16'h4, 16'h4, 64'h0001_0000_0000_0002);
    chk(got_q[1], 64'h1);
    chk(got_q[2], 64'h0);
    run(8'hc7, 16'h08, 16'h0, 16'h4, 64'h0);
    chk(got_q[2], 64'h1);
    run(8'hc4, 16'h10, 16'h0, 16'h0, 64'h2);
    chk(64'(got_q.size()), 64'h0);
    hold = 1'b1;
    fork
      run(8'hc6, 16'h10, 16'h4, 16'h4, 64'h2);
      begin
        repeat (10) @(posedge CLK_SYS);
        #2;
        chk(64'({RES_VALID, A_READY}), 64'h2);
        hold = 1'b0;
        CE = 1'b0;
        #5;
        chk(64'(RES_VALID), 64'h0);
        CE = 1'b1;
      end
    join
    chk(64'(got_q.size()), 64'h4);
    for (int k = 0; k < 4; k++) begin
      chk(got_q[k], 64'(k != 0));
    end
    dot(4'b0101, 4'b1010, 16'h4, 16'h3, 64'h1, 64'h1);
    chk(got_q[0], 64'h8000_0000_0000_0000);
    chk(got_q[1], 64'h8000_0000_0000_0000);
    chk(DATA_FLAGS, 64'h1 << FLG_MZERO);
    dot(4'b0011, 4'b0011, 16'h4, 16'h4, 64'h3, 64'h5);
    chk(DATA_FLAGS, 64'h0);
    chk(got_q[0], 64'h0030_0000_0000_0000);
    chk(got_q[1], 64'h0000_0000_0000_001e);
    slow = 1'b1;
    dot(4'b0111, 4'b0111, 16'h2, 16'h3, 64'h4000_0000_0000_0001, 64'h4000_0000_0000_0001);
    chk(64'(part_u.ov_ptr), 64'h2);
    chk(DATA_FLAGS, (64'h1 << FLG_OVFL) | (64'h1 << FLG_MZERO) | (64'h1 << FLG_INDEF));
    chk(64'(got_q[0][63:48]), 64'(INDEF_EXP));
    chk(64'(got_q[1][63:48]), 64'(MZERO_EXP));
    slow = 1'b0;
    stop_test();
  end
endmodule : vcsd_unit_bench
bind vcsd_unit vcsd_unit_asserts #(.LEN_W(LEN_W)) chk_u (.CLK_SYS, .ARST_N, .CE, .START,
  .BUSY, .DONE, .OPCODE, .RES_DESIG, .REG_X, .REG_Y, .REG_Z, .DATA_FLAGS, .OV_VALID, .OV_X,
  .OV_Y, .OV_READY, .A_READY, .RES_VALID, .RES_READY, .RES_DATA, .RES_TO_REG, .RES_REG,
  .RES_IDX);
